// [rtl/acd_pkg.sv]
// acd_pkg: constants shared by the spi command decoder.
// assumes a 100 MHz system clock and spi mode 0 framing.
package acd_pkg;
  localparam int ACD_WORD_W = 16;
  localparam int ACD_ADDR_W = 6;
  localparam int ACD_CNT_W = 7;
  // command encodings
  localparam logic [15:0] CMD_NOP = 16'h0000;
  localparam logic [15:0] CMD_RESET = 16'h0011;
  localparam logic [15:0] CMD_STANDBY = 16'h0022;
  localparam logic [15:0] CMD_WAKEUP = 16'h0033;
  localparam logic [15:0] CMD_LOCK = 16'h0555;
  localparam logic [15:0] CMD_UNLOCK = 16'h0655;
  localparam logic [2:0] PFX_REGISTER_READ_CMD = 3'h5;
  localparam logic [2:0] PFX_REGISTER_WRITE_CMD = 3'h3;
  localparam logic [2:0] PFX_RHDR = 3'h7;
  localparam logic [2:0] PFX_WACK = 3'h2;
  localparam logic [15:0] RESP_RESET_OK = 16'hff23;
  localparam logic [15:0] RESP_RESET_CUT = 16'h0011;
  // field positions inside a command word
  localparam int FLD_PFX_LSB = 13;
  localparam int FLD_ADDR_LSB = 7;
  // frame layout: words per standard frame
  localparam int FRAME_WORDS = 5;
  // register space
  localparam int REG_COUNT = 64;
  localparam logic [5:0] REG_STATUS = 6'h01;
  localparam logic [5:0] REG_FIRST_RW = 6'h02;
  localparam logic [5:0] REG_LAST_RW = 6'h3e;
  localparam logic [15:0] REG_RST_VAL = 16'h0000;
  localparam int STAT_CRC_ERR_BIT = 12;
  localparam int STAT_LOCK_BIT = 15;
  localparam int STAT_STBY_BIT = 14;
  // wishbone offsets
  localparam logic [7:0] WB_CTRL = 8'h00;
  localparam logic [7:0] WB_STAT = 8'h04;
  localparam logic [7:0] WB_LASTCMD = 8'h08;
  localparam logic [7:0] WB_REGWIN = 8'h0c;
  localparam int CTRL_CRC_FAIL_BIT = 0;
  localparam logic [31:0] WB_UNMAPPED = 32'h0000_0000;
endpackage : acd_pkg

// [rtl/acd_shift_if.sv]
// acd_shift_if: word-level handoff between the spi shifter and decoder.
// assumes both ends run on i_clk.
interface acd_shift_if;
  logic word_valid;
  logic [15:0] word_in;
  logic [7:0] word_idx;
  logic frame_end;
  logic frame_done;
  logic [15:0] word_out;
  logic load_out;
  modport shifter(output word_valid, word_in, word_idx, frame_end,
    frame_done, load_out, input word_out);
  modport decoder(input word_valid, word_in, word_idx, frame_end,
    frame_done, load_out, output word_out);
endinterface : acd_shift_if

// [rtl/acd_spi_shift.sv]
// acd_spi_shift: samples sclk, cs_n and din, assembles 16-bit words.
// assumes pins are asynchronous to i_clk; sclk slower than i_clk/4.
module acd_spi_shift
  import acd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  output logic o_dout,
  acd_shift_if.shifter sif
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic sclk_d;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [3:0] bit_cnt;
    logic [7:0] widx;
    logic full;
    logic dout;
  } acd_sh_type;
  acd_sh_type st_r, st_nxt;
  logic rise, fall, cs_act;

  assign cs_act = ~st_r.s2[1];
  assign rise = st_r.s2[0] & ~st_r.sclk_d;
  assign fall = ~st_r.s2[0] & st_r.sclk_d;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = {i_din, i_cs_n, i_sclk};
    st_nxt.s2 = st_r.s1;
    st_nxt.sclk_d = st_r.s2[0];
    sif.word_valid = 1'b0;
    sif.frame_end = 1'b0;
    sif.frame_done = 1'b0;
    sif.load_out = 1'b0;
    sif.word_in = {st_r.rx[14:0], st_r.s2[2]};
    sif.word_idx = st_r.widx;
    if (!cs_act) begin
      if (st_r.widx != 8'h00 || st_r.bit_cnt != 4'h0 || st_r.full) begin
        sif.frame_end = 1'b1;
        sif.frame_done = st_r.full;
        // msb must stand before the first rising sclk of the next frame
        st_nxt.tx = {sif.word_out[14:0], 1'b0};
        st_nxt.dout = sif.word_out[15];
      end
      st_nxt.bit_cnt = 4'h0;
      st_nxt.widx = 8'h00;
      st_nxt.full = 1'b0;
    end else begin
      if (rise) begin
        st_nxt.rx = {st_r.rx[14:0], st_r.s2[2]};
        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
        if (st_r.bit_cnt == 4'hf) begin
          sif.word_valid = 1'b1;
          st_nxt.widx = st_r.widx + 8'h01;
          if (st_r.widx == 8'(FRAME_WORDS - 1))
            st_nxt.full = 1'b1;
          sif.load_out = 1'b1;
        end
      end
      if (fall) begin
        st_nxt.dout = st_r.tx[15];
        st_nxt.tx = {st_r.tx[14:0], 1'b0};
      end
      if (sif.load_out)
        st_nxt.tx = sif.word_out;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      st_r <= '{s1: 3'h2, s2: 3'h2, default: '0};
    else
      st_r <= st_nxt;
  end

  assign o_dout = st_r.dout;
endmodule : acd_spi_shift

// [rtl/acd_cmd_dec.sv]
// acd_cmd_dec: command decoder for a spi-controlled delta-sigma adc.
// assumes a wishbone classic master and a host driving sclk/cs_n/din.
// Behaviour
// - all-zero command changes nothing; next response is status
// - unknown command words answer like the no-operation command
// - reset latched at frame end; registers return to defaults
// - full reset frame answers ff23; cut frame answers 0011, no reset
// - standby latched at frame end; no effect if already in standby
// - wakeup returns to conversion; no effect if converting
// - locked: only nop, read and unlock accepted; data continues
// - unlock clears the lock state
// - response leads next frame; standby..unlock echo command
// - read command holds 6-bit address and count minus one
// - single read answers register contents directly
// - multi read answers 111 header then registers ascending
// - multi read answer frame carries no conversion data
// - write command holds address and count minus one; data words follow
// - writes land per word; checksum failure only flags status
// - writes to read-only or gap addresses ignored and not counted
// - write answer echoes address with 010 and written count minus one
// - checksum failure skips every command except writes
// - command and register words are 16 bits msb aligned
module acd_cmd_dec
  import acd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  output logic o_dout,
  output logic o_standby,
  output logic o_locked,
  output logic o_conv_data_en,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack
);
  typedef enum logic [1:0] {ST_CMD, ST_WDATA, ST_RDATA, ST_IDLE} acd_st_type;

  typedef struct packed {
    acd_st_type st;
    logic [15:0] cmd;
    logic [15:0] resp;
    logic [5:0] waddr;
    logic [6:0] wleft;
    logic [6:0] wdone;
    logic wany;
    logic [5:0] raddr;
    logic [6:0] rleft;
    logic rburst;
    logic standby;
    logic locked;
    logic crc_err;
    logic crc_fail;
    logic stat_out;
    logic [15:0] lastcmd;
    logic [5:0] regwin;
    logic [31:0] wb_dat;
    logic wb_ack;
  } acd_state_type;

  acd_state_type s_r, s_nxt;
  logic [15:0] regs_r [REG_COUNT];
  logic reg_we;
  logic [5:0] reg_wa;
  logic [15:0] reg_wd;
  logic reg_clr;

  acd_shift_if sif();

  acd_spi_shift u_shift (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_din(i_din),
    .o_dout(o_dout),
    .sif(sif)
  );

  function automatic logic reg_writable(input logic [5:0] a);
    return (a >= REG_FIRST_RW) && (a <= REG_LAST_RW);
  endfunction : reg_writable

  function automatic logic [15:0] status_word(input acd_state_type s);
    logic [15:0] w;
    w = 16'h0000;
    w[STAT_LOCK_BIT] = s.locked;
    w[STAT_STBY_BIT] = s.standby;
    w[STAT_CRC_ERR_BIT] = s.crc_err;
    return w;
  endfunction : status_word

  logic wb_req;
  assign wb_req = i_wb_cyc & i_wb_stb & ~s_r.wb_ack;

  always_comb begin
    s_nxt = s_r;
    reg_we = 1'b0;
    reg_wa = s_r.waddr;
    reg_wd = sif.word_in;
    reg_clr = 1'b0;
    sif.word_out = 16'h0000;
    // next outgoing word of the current frame
    if (s_r.rburst && s_r.rleft != 7'h00) begin
      sif.word_out = regs_r[s_r.raddr];
    end
    if (sif.word_valid) begin
      if (sif.word_idx == 8'h00) begin
        s_nxt.cmd = sif.word_in;
        s_nxt.st = ST_IDLE;
        if (sif.word_in[15:13] == PFX_REGISTER_WRITE_CMD && !s_r.locked) begin
          s_nxt.st = ST_WDATA;
          s_nxt.waddr = sif.word_in[12:7];
          s_nxt.wleft = sif.word_in[6:0];
          s_nxt.wdone = 7'h00;
          s_nxt.wany = 1'b0;
        end
        if (s_r.rburst && s_r.rleft != 7'h00) begin
          s_nxt.raddr = s_r.raddr + 6'h01;
          s_nxt.rleft = s_r.rleft - 7'h01;
        end
      end else if (s_r.st == ST_WDATA) begin
        if (reg_writable(s_r.waddr)) begin
          reg_we = 1'b1;
          if (s_r.wany)
            s_nxt.wdone = s_r.wdone + 7'h01;
          s_nxt.wany = 1'b1;
        end
        s_nxt.waddr = s_r.waddr + 6'h01;
        s_nxt.wleft = s_r.wleft - 7'h01;
        if (s_r.wleft == 7'h00)
          s_nxt.st = ST_IDLE;
      end else if (s_r.rburst && s_r.rleft != 7'h00) begin
        s_nxt.raddr = s_r.raddr + 6'h01;
        s_nxt.rleft = s_r.rleft - 7'h01;
      end
    end
    if (sif.frame_end) begin
      s_nxt.st = ST_CMD;
      s_nxt.rburst = 1'b0;
      s_nxt.rleft = 7'h00;
      s_nxt.lastcmd = s_r.cmd;
      // error flag clears once a status word has gone out, or on a full reset frame
      if (s_r.stat_out)
        s_nxt.crc_err = 1'b0;
      s_nxt.stat_out = 1'b1;
      if (s_r.crc_fail && s_r.cmd[15:13] != PFX_REGISTER_WRITE_CMD) begin
        s_nxt.crc_err = 1'b1;
      end else if (s_r.cmd == CMD_RESET && !s_r.locked) begin
        s_nxt.stat_out = 1'b0;
        if (sif.frame_done) begin
          reg_clr = 1'b1;
          s_nxt.standby = 1'b0;
          s_nxt.locked = 1'b0;
          s_nxt.crc_err = 1'b0;
          s_nxt.resp = RESP_RESET_OK;
        end else begin
          s_nxt.resp = RESP_RESET_CUT;
        end
      end else if (s_r.cmd == CMD_STANDBY && !s_r.locked) begin
        s_nxt.stat_out = 1'b0;
        s_nxt.standby = 1'b1;
        s_nxt.resp = CMD_STANDBY;
      end else if (s_r.cmd == CMD_WAKEUP && !s_r.locked) begin
        s_nxt.stat_out = 1'b0;
        s_nxt.standby = 1'b0;
        s_nxt.resp = CMD_WAKEUP;
      end else if (s_r.cmd == CMD_LOCK && !s_r.locked) begin
        s_nxt.stat_out = 1'b0;
        s_nxt.locked = 1'b1;
        s_nxt.resp = CMD_LOCK;
      end else if (s_r.cmd == CMD_UNLOCK) begin
        s_nxt.stat_out = 1'b0;
        s_nxt.locked = 1'b0;
        s_nxt.resp = CMD_UNLOCK;
      end else if (s_r.cmd[15:13] == PFX_REGISTER_READ_CMD) begin
        s_nxt.stat_out = 1'b0;
        if (s_r.cmd[6:0] == 7'h00) begin
          s_nxt.resp = regs_r[s_r.cmd[12:7]];
        end else begin
          s_nxt.resp = {PFX_RHDR, s_r.cmd[12:0]};
          s_nxt.rburst = 1'b1;
          s_nxt.raddr = s_r.cmd[12:7];
          s_nxt.rleft = s_r.cmd[6:0] + 7'h01;
        end
      end else if (s_r.cmd[15:13] == PFX_REGISTER_WRITE_CMD && !s_r.locked) begin
        s_nxt.stat_out = 1'b0;
        s_nxt.resp = {PFX_WACK, s_r.cmd[12:7], s_r.wdone};
        if (s_r.crc_fail)
          s_nxt.crc_err = 1'b1;
      end
      // status answer carries the flags as they stand after this frame
      if (s_nxt.stat_out)
        s_nxt.resp = status_word(s_nxt);
    end
    // frame-start response load
    if (sif.frame_end)
      sif.word_out = s_nxt.resp;
    // wishbone slave
    s_nxt.wb_ack = wb_req;
    if (wb_req) begin
      s_nxt.wb_dat = WB_UNMAPPED;
      case (i_wb_adr)
        WB_CTRL: begin
          if (i_wb_we && i_wb_sel[0])
            s_nxt.crc_fail = i_wb_dat[CTRL_CRC_FAIL_BIT];
          s_nxt.wb_dat = {31'h0, s_r.crc_fail};
        end
        WB_STAT: s_nxt.wb_dat = {16'h0, status_word(s_r)};
        WB_LASTCMD: s_nxt.wb_dat = {16'h0, s_r.lastcmd};
        WB_REGWIN: begin
          if (i_wb_we && i_wb_sel[0])
            s_nxt.regwin = i_wb_dat[5:0];
          s_nxt.wb_dat = {10'h0, regs_r[s_r.regwin], s_r.regwin};
        end
        default: s_nxt.wb_dat = WB_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '{st: ST_CMD, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
          regs_r[gi] <= REG_RST_VAL;
        else if (reg_clr)
          regs_r[gi] <= REG_RST_VAL;
        else if (reg_we && reg_wa == 6'(gi))
          regs_r[gi] <= reg_wd;
      end
    end
  endgenerate

  assign o_standby = s_r.standby;
  assign o_locked = s_r.locked;
  assign o_conv_data_en = ~s_r.standby & ~s_r.rburst;
  assign o_wb_dat = s_r.wb_dat;
  assign o_wb_ack = s_r.wb_ack;

  property p_lock_blocks_standby;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sif.frame_end && s_r.locked && s_r.cmd == CMD_STANDBY
        && !s_r.standby) |=> !s_r.standby;
  endproperty
  a_lock_blocks_standby: assert property (p_lock_blocks_standby)
    else $error("standby taken while locked");

  property p_unlock;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sif.frame_end && !s_r.crc_fail && s_r.cmd == CMD_UNLOCK)
        |=> !s_r.locked;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock did not clear lock");

  property p_reset_ack;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sif.frame_end && sif.frame_done && !s_r.crc_fail && !s_r.locked
        && s_r.cmd == CMD_RESET) |=> s_r.resp == RESP_RESET_OK
        && regs_r[REG_FIRST_RW] == REG_RST_VAL;
  endproperty
  a_reset_ack: assert property (p_reset_ack)
    else $error("reset frame not acknowledged");

  property p_reset_cut;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sif.frame_end && !sif.frame_done && !s_r.crc_fail && !s_r.locked
        && s_r.cmd == CMD_RESET) |=> s_r.resp == RESP_RESET_CUT;
  endproperty
  a_reset_cut: assert property (p_reset_cut)
    else $error("cut reset frame misanswered");

  property p_standby_echo;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sif.frame_end && !s_r.crc_fail && !s_r.locked
        && s_r.cmd == CMD_STANDBY) |=> s_r.standby
        && s_r.resp == CMD_STANDBY;
  endproperty
  a_standby_echo: assert property (p_standby_echo)
    else $error("standby not entered or echoed");

  property p_wakeup;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sif.frame_end && !s_r.crc_fail && !s_r.locked
        && s_r.cmd == CMD_WAKEUP) |=> !s_r.standby;
  endproperty
  a_wakeup: assert property (p_wakeup)
    else $error("wakeup left standby set");

  property p_rhdr;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sif.frame_end && !s_r.crc_fail && s_r.cmd[15:13] == PFX_REGISTER_READ_CMD
        && s_r.cmd[6:0] != 7'h00) |=> s_r.resp[15:13] == PFX_RHDR
        && s_r.resp[12:0] == $past(s_r.cmd[12:0]) && !o_conv_data_en;
  endproperty
  a_rhdr: assert property (p_rhdr)
    else $error("read burst header wrong");

  property p_wr_ro;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sif.word_valid && sif.word_idx != 8'h00 && s_r.st == ST_WDATA
        && !reg_writable(s_r.waddr)) |-> !reg_we;
  endproperty
  a_wr_ro: assert property (p_wr_ro)
    else $error("write hit a read-only address");

  c_reset: cover property (@(posedge i_clk) sif.frame_end
    && s_r.cmd == CMD_RESET);
  c_burst: cover property (@(posedge i_clk) s_r.rburst);
  c_write: cover property (@(posedge i_clk) reg_we);
  c_crc: cover property (@(posedge i_clk) sif.frame_end && s_r.crc_fail);

  property p_crc_flag;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sif.frame_end && s_r.crc_fail) |=> s_r.crc_err;
  endproperty
  a_crc_flag: assert property (p_crc_flag)
    else $error("checksum failure not flagged");

  property p_single_read;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sif.frame_end && !s_r.crc_fail && s_r.cmd[15:13] == PFX_REGISTER_READ_CMD
        && s_r.cmd[6:0] == 7'h00)
        |=> s_r.resp == $past(regs_r[s_r.cmd[12:7]]);
  endproperty
  a_single_read: assert property (p_single_read)
    else $error("single read answered wrong word");
endmodule : acd_cmd_dec

// [test/acd_host_model.sv]
// acd_host_model: spi controller model, mode 0, msb first, 16-bit words.
// assumes i_clk at 100 MHz; sclk half period is HALF i_clk cycles.
module acd_host_model #(
  parameter int HALF = 8
) (
  input wire logic i_clk,
  input wire logic i_dout,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] tx [12];
  logic [15:0] rx [12];

  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wt

  // nbits below nw*16 cuts the frame short on purpose
  task automatic frame(input int nw, input int nbits);
    int i;
    for (i = 0; i < 12; i++) begin
      rx[i] = 16'h0000;
    end
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    for (i = 0; i < nbits && i < nw * 16; i++) begin
      o_din <= tx[i / 16][15 - i % 16];
      wt(HALF);
      o_sclk <= 1'b1;
      rx[i / 16][15 - i % 16] = i_dout;
      wt(HALF);
      o_sclk <= 1'b0;
    end
    wt(HALF);
    o_cs_n <= 1'b1;
    // released line must not keep showing the last bit
    o_din <= ~o_din;
    wt(4 * HALF);
  endtask : frame
endmodule : acd_host_model

// [test/acd_cmd_dec_tb.sv]
// acd_cmd_dec_tb: self-checking bench for the spi command decoder.
// assumes acd_host_model drives the spi pins; wishbone is driven here.
module acd_cmd_dec_tb
  import acd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // stands in for register_acquisition_delay, in i_clk cycles
  localparam int ACQ_WAIT = 100;
  localparam logic [15:0] ZW = 16'h0000;
  // stand-in address of converter_power_control
  localparam logic [5:0] CONV_PWR_REG = 6'h10;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic sclk, cs_n, din, dout, standby, locked, conv_en, ack;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, q;
  int miscompares = 0;
  int compares = 0;

  always #5 i_clk = ~i_clk;

  acd_cmd_dec dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_din(din), .o_dout(dout), .o_standby(standby), .o_locked(locked),
    .o_conv_data_en(conv_en), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf),
    .o_wb_dat(rdat), .o_wb_ack(ack)
  );

  acd_host_model #(.HALF(8)) host_u (
    .i_clk(i_clk), .i_dout(dout), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_din(din)
  );

  task automatic chk(input logic [31:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got,
        exp);
    end
  endtask : chk

  task automatic rsp(input logic [15:0] exp, input string what);
    chk(host_u.rx[0], exp, what);
  endtask : rsp

  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge i_clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  function automatic logic [15:0] cw(input logic [2:0] p,
      input logic [5:0] a, input logic [6:0] n);
    return {p, a, n};
  endfunction : cw

  task automatic xf(input logic [15:0] c, d1, d2, input int nb);
    // no checksum word: input checking is off
    host_u.tx = '{default: ZW};
    host_u.tx[0] = c;
    host_u.tx[1] = d1;
    host_u.tx[2] = d2;
    host_u.frame(5, nb);
  endtask : xf

  task automatic x(input logic [15:0] c);
    xf(c, ZW, ZW, 80);
  endtask : x

  task automatic t_idle();
    wb(1'b0, WB_STAT, 32'h0000_0000);
    chk(q, 32'h0000_0000, "status after reset");
    wb(1'b1, 8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0000_0000);
    chk(q, WB_UNMAPPED, "unmapped read");
    chk({standby, locked}, 2'b00, "mode after reset");
    x(CMD_NOP);
    x(16'h1234);
    rsp(16'h0000, "nop answer");
    x(CMD_NOP);
    rsp(16'h0000, "invalid answer");
    $display("test idle done");
  endtask : t_idle

  task automatic t_modes();
    xf(cw(PFX_REGISTER_WRITE_CMD, CONV_PWR_REG, 7'h00), 16'h0000, ZW, 80);
    x(CMD_STANDBY);
    rsp(cw(PFX_WACK, CONV_PWR_REG, 7'h00), "power off ack");
    chk({standby, conv_en}, 2'b10, "standby entry");
    x(CMD_STANDBY);
    rsp(CMD_STANDBY, "standby echo");
    chk(standby, 1'b1, "standby again");
    x(CMD_WAKEUP);
    rsp(CMD_STANDBY, "repeat standby echo");
    chk({standby, conv_en}, 2'b01, "wakeup");
    x(CMD_WAKEUP);
    rsp(CMD_WAKEUP, "wakeup echo");
    x(CMD_NOP);
    rsp(CMD_WAKEUP, "repeat wakeup echo");
    chk(standby, 1'b0, "still converting");
    xf(cw(PFX_REGISTER_WRITE_CMD, CONV_PWR_REG, 7'h00), 16'h0001, ZW, 80);
    $display("test modes done");
  endtask : t_modes

  task automatic t_regs();
    xf(cw(PFX_REGISTER_WRITE_CMD, 6'h02, 7'h01), 16'hbeef, 16'h1234, 80);
    x(cw(PFX_REGISTER_READ_CMD, 6'h03, 7'h00));
    rsp(cw(PFX_WACK, 6'h02, 7'h01), "write answer");
    x(cw(PFX_REGISTER_READ_CMD, 6'h02, 7'h02));
    rsp(16'h1234, "single read");
    x(CMD_NOP);
    rsp(cw(PFX_RHDR, 6'h02, 7'h02), "burst header");
    chk({host_u.rx[1], host_u.rx[2]}, 32'hbeef_1234, "burst");
    chk(host_u.rx[3], 16'h0000, "burst tail");
    xf(cw(PFX_REGISTER_WRITE_CMD, 6'h01, 7'h01), 16'hffff, 16'h5a5a, 80);
    x(cw(PFX_REGISTER_READ_CMD, 6'h02, 7'h00));
    rsp(cw(PFX_WACK, 6'h01, 7'h00), "read-only skipped");
    x(CMD_NOP);
    rsp(16'h5a5a, "write past read-only");
    x(CMD_NOP);
    rsp(16'h0000, "status untouched");
    $display("test regs done");
  endtask : t_regs

  task automatic t_lock();
    x(CMD_LOCK);
    chk(locked, 1'b1, "lock");
    x(CMD_STANDBY);
    rsp(CMD_LOCK, "lock echo");
    chk({standby, conv_en}, 2'b01, "locked standby");
    x(cw(PFX_REGISTER_READ_CMD, 6'h02, 7'h00));
    rsp(16'h8000, "ignored answers status");
    x(CMD_UNLOCK);
    rsp(16'h5a5a, "read while locked");
    x(CMD_NOP);
    rsp(CMD_UNLOCK, "unlock echo");
    chk(locked, 1'b0, "unlock");
    $display("test lock done");
  endtask : t_lock

  task automatic t_crc();
    wb(1'b1, WB_CTRL, 32'h0000_0001);
    x(CMD_STANDBY);
    chk(standby, 1'b0, "failed check skips");
    xf(cw(PFX_REGISTER_WRITE_CMD, 6'h03, 7'h00), 16'h7777, ZW, 80);
    rsp(16'h1000, "error answers status");
    wb(1'b0, WB_STAT, 32'h0000_0000);
    chk(q[STAT_CRC_ERR_BIT], 1'b1, "error flag");
    wb(1'b1, WB_CTRL, 32'h0000_0000);
    x(cw(PFX_REGISTER_READ_CMD, 6'h03, 7'h00));
    x(CMD_NOP);
    rsp(16'h7777, "write despite error");
    $display("test crc done");
  endtask : t_crc

  task automatic t_rst();
    xf(CMD_RESET, ZW, ZW, 24);
    x(cw(PFX_REGISTER_READ_CMD, 6'h02, 7'h00));
    rsp(RESP_RESET_CUT, "cut reset");
    x(CMD_RESET);
    rsp(16'h5a5a, "no reset on cut frame");
    repeat (ACQ_WAIT) @(posedge i_clk);
    x(cw(PFX_REGISTER_READ_CMD, 6'h02, 7'h00));
    rsp(RESP_RESET_OK, "reset ack");
    x(CMD_NOP);
    rsp(REG_RST_VAL, "register default");
    $display("test reset done");
  endtask : t_rst

  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    t_idle();
    t_modes();
    t_regs();
    t_lock();
    t_crc();
    t_rst();
    results();
  end

  // about 32 frames of 1.3k cycles each; roughly twice that as margin
  initial begin
    #900000;
    miscompares++;
    results();
  end
endmodule : acd_cmd_dec_tb
